// ==== rpc_reset_intrusion_ctrl.sv ====
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "rpc_regs.svh"
module rpc_reset_intrusion_ctrl #(
	parameter int XOR_N        = 8,
	parameter int POR_HOLD_CYC = `RPC_POR_HOLD_CYC,
	parameter int FAN_WAIT_CYC = `RPC_FAN_WAIT_CYC
) (
	// System
	input  logic                  clk_sys,
	input  logic                  srst,
	// Register bus
	input  rpc_pkg::rpc_axi_req_t axi_req,
	output rpc_pkg::rpc_axi_rsp_t axi_rsp,
	// Supply and reset pin
	input  logic                  supply_ok,
	input  logic                  reset_pin_i,
	output logic                  reset_pin_o,
	output logic                  reset_pin_oe,
	output logic                  subset_reset,
	// Intrusion and termination sense
	input  logic                  intrusion_input,
	input  logic [1:0]            termination_sense_input,
	input  logic [7:0]            battery_rail_value,
	output logic                  intrusion_armed,
	output logic                  alert,
	// Monitoring and fans
	input  logic                  main_rail,
	input  logic                  dedicated_fan_prog,
	output logic                  early_mon_en,
	output logic                  all_mon_en,
	output logic                  quiet_start_gate,
	output logic [2:0]            fan_shared_oe,
	output logic                  dedicated_fan_drive,
	// Board test
	input  logic [XOR_N-1:0]      xor_in,
	output logic                  xor_pin_o,
	output logic                  xor_pin_oe
);
	import rpc_pkg::*;

	localparam int SW = XOR_N + 6;

	// ----------------------------------------------------------------
	// Input synchronisers and timers
	// ----------------------------------------------------------------
	logic [SW-1:0]    raw_in, sync_in;
	logic             sup_s, pin_s, intr_s, main_s;
	logic [1:0]       term_s;
	logic [XOR_N-1:0] xor_s;
	logic             por_done, fan_exp;
	rpc_state_t       s, next_s;

	assign raw_in = {xor_in, termination_sense_input, main_rail, intrusion_input,
		reset_pin_i, supply_ok};
	assign {xor_s, term_s, main_s, intr_s, pin_s, sup_s} = sync_in;

	rpc_sync #(.W(SW)) u_sync (
		.clk_sys (clk_sys),
		.srst    (srst),
		.d       (raw_in),
		.q       (sync_in)
	);

	rpc_timer #(.COUNT(POR_HOLD_CYC)) u_por_tmr (
		.clk_sys (clk_sys),
		.srst    (srst),
		.restart (~sup_s),
		.run     (s.pu == RPC_PU_HOLD),
		.expired (por_done)
	);

	rpc_timer #(.COUNT(FAN_WAIT_CYC)) u_fan_tmr (
		.clk_sys (clk_sys),
		.srst    (srst),
		.restart (main_s & ~s.main_prev),
		.run     (main_s),
		.expired (fan_exp)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic rpc_mapped(input logic [11:0] a);
		logic [7:0] i;
		i = a[9:2];
		if (a[11:10] != 2'h0) begin
			return 1'b0;
		end
		case (i)
			`RPC_IDX_CFG0, `RPC_IDX_CFG1, `RPC_IDX_CFG3, `RPC_IDX_TMASK,
			`RPC_IDX_BATLIM, `RPC_IDX_KEY, `RPC_IDX_BATVAL, `RPC_IDX_HSTAT,
			`RPC_IDX_BSTAT, `RPC_IDX_STATE: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// Registers touched by hardware and software reset alike
	function automatic rpc_state_t rpc_soft_defaults(input rpc_state_t x);
		rpc_state_t y;
		y = x;
		if (!x.cfg1[`RPC_BIT_LOCK]) begin // R7
			y.cfg0  = `RPC_DEF_CFG0;
			y.cfg1  = `RPC_DEF_CFG1;
			y.cfg3  = `RPC_DEF_CFG3;
			y.tmask = `RPC_DEF_TMASK;
		end
		y.key       = `RPC_DEF_KEY; // R9
		y.term_host = 2'h0;
		y.term_bmc  = 2'h0;
		return y;
	endfunction

	function automatic logic [7:0] rpc_read(input rpc_state_t x, input logic [7:0] i,
		input logic [7:0] bat);
		case (i)
			`RPC_IDX_CFG0:   return x.cfg0;
			`RPC_IDX_CFG1:   return x.cfg1;
			`RPC_IDX_CFG3:   return x.cfg3;
			`RPC_IDX_TMASK:  return x.tmask;
			`RPC_IDX_BATLIM: return x.bat_lim;
			`RPC_IDX_KEY:    return x.key;
			`RPC_IDX_BATVAL: return bat;
			`RPC_IDX_HSTAT:  return {x.intr_lat, 1'b0, x.term_host, 4'h0};
			`RPC_IDX_BSTAT:  return {2'h0, x.term_bmc, 4'h0};
			`RPC_IDX_STATE:  return {3'h0, x.traffic, x.fan3_full, x.bat_lim <= bat, x.pu};
			default:         return 8'h00;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic       arm, main_rise, intr_rise, wr_go, sw_go, wr_ok, lock;
	logic [7:0] wi;

	assign arm       = battery_rail_value >= s.bat_lim;
	assign main_rise = main_s & ~s.main_prev;
	assign intr_rise = intr_s & ~s.intr_prev;
	assign wr_go     = s.aw_got & s.w_got & ~s.bvalid;
	assign wi        = s.awaddr[9:2];
	assign wr_ok     = rpc_mapped(s.awaddr);
	assign lock      = s.cfg1[`RPC_BIT_LOCK];

	always_comb begin
		next_s            = s;
		sw_go             = 1'b0;
		next_s.quiet_gate = main_rise; // R16
		next_s.early_mon  = 1'b1; // R15
		next_s.main_prev  = main_s;
		next_s.intr_prev  = intr_s;
		case (s.pu)
			RPC_PU_HOLD: begin
				if (por_done && sup_s) begin // R3
					next_s.pu    = RPC_PU_RUN;
					next_s.guard = `RPC_GUARD_CYC;
				end
			end
			RPC_PU_RUN: begin
				if (!sup_s) begin
					next_s.pu = RPC_PU_HOLD;
				end else if (s.guard != 2'h0) begin
					next_s.guard = s.guard - 2'h1;
				end else if (!pin_s) begin // R5
					next_s.pu = RPC_PU_EXT;
				end
			end
			RPC_PU_EXT: begin
				if (!sup_s) begin
					next_s.pu = RPC_PU_HOLD;
				end else if (pin_s) begin
					next_s.pu = RPC_PU_RUN;
				end
			end
			default: begin
				next_s.pu = RPC_PU_HOLD;
			end
		endcase
		if (main_rise) begin
			next_s.traffic   = 1'b0;
			next_s.fan3_full = 1'b0;
		end
		// Bus channels
		if (axi_req.awvalid && axi_rsp.awready) begin
			next_s.aw_got  = 1'b1;
			next_s.awaddr  = axi_req.awaddr;
			next_s.traffic = 1'b1;
		end
		if (axi_req.wvalid && axi_rsp.wready) begin
			next_s.w_got = 1'b1;
			next_s.wdata = axi_req.wdata[7:0];
			next_s.wlane = axi_req.wstrb[0];
		end
		if (s.bvalid && axi_req.bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s.rvalid && axi_req.rready) begin
			next_s.rvalid = 1'b0;
		end
		if (axi_req.arvalid && axi_rsp.arready) begin
			next_s.rvalid  = 1'b1;
			next_s.traffic = 1'b1;
			next_s.rdata   = rpc_read(s, axi_req.araddr[9:2], battery_rail_value);
			next_s.rresp   = rpc_mapped(axi_req.araddr) ? `RPC_RESP_OKAY : `RPC_RESP_SLVERR;
		end
		if (wr_go) begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = wr_ok ? `RPC_RESP_OKAY : `RPC_RESP_SLVERR;
			if (wr_ok && s.wlane) begin
				case (wi)
					`RPC_IDX_CFG0: begin
						if (!lock) begin
							next_s.cfg0 = {1'b0, s.wdata[6:0]};
							sw_go = s.wdata[`RPC_BIT_SWRST] && (s.key == `RPC_UNLOCK_KEY); // R8
						end
					end
					`RPC_IDX_CFG1: begin
						if (!lock) begin
							next_s.cfg1 = s.wdata;
						end
					end
					`RPC_IDX_CFG3: begin
						if (!lock) begin
							next_s.cfg3 = s.wdata;
						end
					end
					`RPC_IDX_TMASK: begin
						if (!lock) begin
							next_s.tmask = s.wdata;
						end
					end
					`RPC_IDX_BATLIM: next_s.bat_lim = s.wdata;
					`RPC_IDX_KEY:    next_s.key = s.wdata;
					`RPC_IDX_HSTAT: begin
						next_s.term_host = s.term_host & ~s.wdata[`RPC_TERM_HI:`RPC_TERM_LO];
					end
					`RPC_IDX_BSTAT: begin
						next_s.term_bmc = s.term_bmc & ~s.wdata[`RPC_TERM_HI:`RPC_TERM_LO];
					end
					default: begin
					end
				endcase
			end
		end
		// Subset reset from the pin or from software
		next_s.sub_rst = sw_go | (s.pu == RPC_PU_EXT);
		if (next_s.sub_rst) begin
			next_s = rpc_soft_defaults(next_s); // R7 R10
		end
		// Events: a set in the clearing cycle wins
		next_s.term_host = next_s.term_host | term_s; // R1
		next_s.term_bmc  = next_s.term_bmc | term_s; // R1
		if (s.cfg3[`RPC_BIT_CIR]) begin
			next_s.intr_lat = 1'b0; // R12
		end
		if (intr_rise && arm) begin
			next_s.intr_lat = 1'b1; // R11 R13
		end
		// A stale expiry from an earlier main rail period must not force the fan
		if (fan_exp && !next_s.traffic && main_s && !main_rise) begin
			next_s.fan3_full = 1'b1; // R18
		end
		next_s.fan3_out = next_s.fan3_full | (next_s.traffic & dedicated_fan_prog); // R18
		next_s.alert = (next_s.intr_lat & main_s) // R14
			| (|(next_s.term_host & ~next_s.tmask[`RPC_TERM_HI:`RPC_TERM_LO])); // R2
		next_s.xor_oe = next_s.cfg3[`RPC_BIT_XOR] & ~(^xor_s); // R21 R23
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s         <= '0; // R4
			s.pu      <= RPC_PU_HOLD;
			s.cfg0    <= `RPC_DEF_CFG0;
			s.cfg1    <= `RPC_DEF_CFG1;
			s.cfg3    <= `RPC_DEF_CFG3;
			s.tmask   <= `RPC_DEF_TMASK;
			s.bat_lim <= `RPC_DEF_BATLIM;
			s.key     <= `RPC_DEF_KEY;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_comb begin
		axi_rsp         = '0;
		axi_rsp.awready = ~s.aw_got & ~s.bvalid;
		axi_rsp.wready  = ~s.w_got & ~s.bvalid;
		axi_rsp.bvalid  = s.bvalid;
		axi_rsp.bresp   = s.bresp;
		axi_rsp.arready = ~s.rvalid;
		axi_rsp.rvalid  = s.rvalid;
		axi_rsp.rdata   = {24'h0, s.rdata};
		axi_rsp.rresp   = s.rresp;
	end

	assign reset_pin_o         = 1'b0;
	assign reset_pin_oe        = (s.pu == RPC_PU_HOLD); // R3
	assign subset_reset        = s.sub_rst;
	assign intrusion_armed     = arm; // R13
	assign alert               = s.alert;
	assign early_mon_en        = s.early_mon; // R15
	assign all_mon_en          = s.cfg1[`RPC_BIT_SETUP]; // R19
	assign quiet_start_gate    = s.quiet_gate;
	assign fan_shared_oe       = 3'h0; // R17
	assign dedicated_fan_drive = s.fan3_out;
	assign xor_pin_o           = 1'b0;
	assign xor_pin_oe          = s.xor_oe; // R22

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	pin_hold_a: assert property ((s.pu == RPC_PU_HOLD) |-> reset_pin_oe && !reset_pin_o) // R3
		else $error("reset pin not held during powerup");
	brownout_a: assert property (!sup_s |=> s.pu == RPC_PU_HOLD) // R3
		else $error("supply loss did not return to hold");
	ext_reset_a: assert property ((s.pu == RPC_PU_RUN && s.guard == 2'h0 && sup_s && !pin_s)
		|=> s.pu == RPC_PU_EXT ##1 subset_reset) // R5
		else $error("external reset not taken");
	term_set_a: assert property (term_s[0] |=> s.term_host[0] && s.term_bmc[0]) // R1
		else $error("termination event not recorded");
	term_mask_a: assert property ((!s.intr_lat
		&& (s.term_host & ~s.tmask[`RPC_TERM_HI:`RPC_TERM_LO]) == 2'h0)
		|-> !alert) // R2
		else $error("masked termination raised alert");
	key_clear_a: assert property (sw_go |=> s.key == `RPC_DEF_KEY && s.sub_rst) // R9
		else $error("key not cleared after software reset");
	key_need_a: assert property ((wr_go && wr_ok && s.wlane && wi == `RPC_IDX_CFG0
		&& s.wdata[`RPC_BIT_SWRST] && !lock && s.key != `RPC_UNLOCK_KEY && s.pu == RPC_PU_RUN)
		|=> !s.sub_rst) // R8
		else $error("software reset without key");
	lim_keep_a: assert property (s.sub_rst && !$past(wr_go) |-> $stable(s.bat_lim)) // R7
		else $error("limit register lost on subset reset");
	intr_set_a: assert property ((intr_rise && arm) |=> s.intr_lat) // R11
		else $error("intrusion not latched");
	intr_hold_a: assert property ((s.intr_lat && !s.cfg3[`RPC_BIT_CIR]) |=> s.intr_lat) // R12
		else $error("intrusion bit dropped without clear");
	intr_off_a: assert property ((!arm && !s.intr_lat) |=> !s.intr_lat) // R13
		else $error("intrusion latched with battery low");
	intr_wait_a: assert property ((!$past(main_s) && s.term_host == 2'h0) |-> !alert) // R14
		else $error("intrusion alert while main rail off");
	fan_full_a: assert property ((fan_exp && main_s && !main_rise && !next_s.traffic)
		|=> dedicated_fan_drive [*2]) // R18
		else $error("dedicated fan not forced to full");
	xor_out_a: assert property (s.cfg3[`RPC_BIT_XOR]
		|-> xor_pin_oe == !(^$past(xor_s))) // R23
		else $error("xor output wrong");

	hold_release_c: cover property (s.pu == RPC_PU_HOLD ##1 s.pu == RPC_PU_RUN);
	sw_reset_c: cover property (sw_go ##1 s.sub_rst);
	intr_alert_c: cover property (intr_rise ##[1:4] alert);
	fan_full_c: cover property ($rose(s.fan3_full));
endmodule

// ==== rpc_regs.svh ====
// Function
// [R1] Termination assertion sets status bits four/five
// [R2] Mask register bit blocks termination from alert
// [R3] Hold reset pin low 180 ms after supply
// [R4] Power-on reset loads all register defaults
// [R5] External low on reset pin resets device
// [R6] Host waits 180 ms, pulses over 0.8 ms
// [R7] Hardware reset restores subset, keeps limits, locked
// [R8] Software reset needs unlock key written first
// [R9] Key register returns default after software reset
// [R10] Software reset restores same set as hardware
// [R11] Intrusion rising edge latches status and alerts
// [R12] Intrusion bit held until clear bit written
// [R13] Battery below limit disables intrusion monitoring
// [R14] Intrusion alert waits for main rail power
// [R15] Diode, main, battery channels monitored at once
// [R16] Main rail switch-on gates quiet startup counter
// [R17] Shared fan drives float high at powerup
// [R18] Dedicated fan full after silent 4.6 s
// [R19] Other channels wait for setup-complete bit
// [R20] Host configures fully before setting setup bit
// [R21] Config 3 bit six enters XOR tree
// [R22] XOR result on open-drain pin, inputs selected
// [R23] XOR output is parity of all inputs
`ifndef RPC_REGS_SVH
`define RPC_REGS_SVH

`define RPC_CLK_MHZ       25
`define RPC_POR_HOLD_MS   180
`define RPC_POR_HOLD_CYC  (`RPC_POR_HOLD_MS * 1000 * `RPC_CLK_MHZ)
`define RPC_FAN_WAIT_MS   4600
`define RPC_FAN_WAIT_CYC  (`RPC_FAN_WAIT_MS * 1000 * `RPC_CLK_MHZ)
`define RPC_GUARD_CYC     2'h3

`define RPC_IDX_CFG0      8'h00
`define RPC_IDX_CFG1      8'h01
`define RPC_IDX_CFG3      8'h03
`define RPC_IDX_TMASK     8'h35
`define RPC_IDX_BATLIM    8'h75
`define RPC_IDX_KEY       8'h7b
`define RPC_IDX_BATVAL    8'h93
`define RPC_IDX_HSTAT     8'hbe
`define RPC_IDX_BSTAT     8'hc6
`define RPC_IDX_STATE     8'he0

`define RPC_DEF_CFG0      8'h20
`define RPC_DEF_CFG1      8'h81
`define RPC_DEF_CFG3      8'h00
`define RPC_DEF_TMASK     8'h00
`define RPC_DEF_BATLIM    8'h80
`define RPC_DEF_KEY       8'h00
`define RPC_UNLOCK_KEY    8'h6d

`define RPC_BIT_SWRST     7
`define RPC_BIT_LOCK      6
`define RPC_BIT_SETUP     5
`define RPC_BIT_XOR       6
`define RPC_BIT_CIR       5
`define RPC_BIT_INTR      7
`define RPC_TERM_HI       5
`define RPC_TERM_LO       4

`define RPC_RESP_OKAY     2'h0
`define RPC_RESP_SLVERR   2'h2

`endif

// ==== rpc_pkg.sv ====
package rpc_pkg;

	typedef enum logic [1:0] {
		RPC_PU_HOLD = 2'b00,
		RPC_PU_RUN  = 2'b01,
		RPC_PU_EXT  = 2'b10
	} rpc_pu_t;

	typedef struct packed {
		logic        awvalid;
		logic [11:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [11:0] araddr;
		logic        rready;
	} rpc_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} rpc_axi_rsp_t;

	typedef struct packed {
		rpc_pu_t     pu;
		logic [1:0]  guard;
		logic [7:0]  cfg0, cfg1, cfg3, tmask, bat_lim, key;
		logic        intr_lat, intr_prev, main_prev;
		logic [1:0]  term_host, term_bmc;
		logic        traffic, fan3_full, fan3_out;
		logic        alert, xor_oe, quiet_gate, sub_rst, early_mon;
		logic        aw_got, w_got, wlane, bvalid, rvalid;
		logic [11:0] awaddr;
		logic [7:0]  wdata, rdata;
		logic [1:0]  bresp, rresp;
	} rpc_state_t;

endpackage

// ==== rpc_sync.sv ====
`timescale 1ns/100ps
module rpc_sync #(
	parameter int W = 1
) (
	// System
	input  logic         clk_sys,
	input  logic         srst,
	// Data
	input  logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} rpc_sync_st_t;

	rpc_sync_st_t s, next_s;

	always_comb begin
		next_s    = s;
		next_s.s1 = d;
		next_s.s2 = s.s1;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign q = s.s2;
endmodule

// ==== rpc_timer.sv ====
`timescale 1ns/100ps
module rpc_timer #(
	parameter int COUNT = 4
) (
	// System
	input  logic clk_sys,
	input  logic srst,
	// Control
	input  logic restart,
	input  logic run,
	output logic expired
);
	localparam int CW = $clog2(COUNT + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          done;
	} rpc_tmr_st_t;

	rpc_tmr_st_t s, next_s;

	always_comb begin
		next_s = s;
		if (restart) begin
			next_s.cnt  = CW'(COUNT - 1);
			next_s.done = 1'b0;
		end else if (run && !s.done) begin
			if (s.cnt == '0) begin
				next_s.done = 1'b1;
			end else begin
				next_s.cnt = s.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s.cnt  <= CW'(COUNT - 1);
			s.done <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	assign expired = s.done;
endmodule

// ==== rpc_board_model.sv ====
`timescale 1ns/100ps
module rpc_board_model #(
	parameter int HOLD = 8
) (
	// System
	input  wire logic clk_sys,
	// Device pins
	input  wire logic reset_pin_o,
	input  wire logic reset_pin_oe,
	input  wire logic xor_pin_o,
	input  wire logic xor_pin_oe,
	// Board side
	input  wire logic ext_req,
	output wire logic reset_wire,
	output wire logic xor_wire
);
	int cnt = 0;

	// Both nets are open drain with pull-ups
	assign reset_wire = (reset_pin_oe ? reset_pin_o : 1'b1) & (cnt == 0);
	assign xor_wire   = xor_pin_oe ? xor_pin_o : 1'b1;

	// Pulse only after the device has let go, and hold it long enough to register
	always @(posedge clk_sys) begin
		if (cnt != 0)
			cnt <= cnt - 1;
		else if (ext_req && reset_wire)
			cnt <= HOLD;
	end
endmodule

// ==== tb.sv ====
`timescale 1ns/100ps
module tb;
	import rpc_pkg::*;
	// --------------------
	// Harness
	// --------------------
	logic         clk_sys = 0;
	logic         srst = 1;
	rpc_axi_req_t req = '{bready: 1'b1, rready: 1'b1, default: '0};
	rpc_axi_rsp_t rsp;
	logic         intr = 0, main_rail = 0, prog = 0, ext_req = 0, sup = 1;
	logic [1:0]   term = 0, rr;
	logic [7:0]   bat = 8'h90, xin = 8'h00;
	logic [31:0]  rd;
	logic         rst_w, xor_w, rst_o, rst_oe, xor_o, xor_oe, sub, armed, alert;
	logic         emon, amon, qgate, fan3;
	logic [2:0]   fsh;
	int           num_errors = 0, tests_run = 0, qcnt = 0, scnt = 0;

	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (qgate === 1'b1)
			qcnt <= qcnt + 1;
		if (sub === 1'b1)
			scnt <= scnt + 1;
	end

	rpc_reset_intrusion_ctrl #(.XOR_N(8), .POR_HOLD_CYC(20), .FAN_WAIT_CYC(50)) dut (
		.clk_sys(clk_sys), .srst(srst), .axi_req(req), .axi_rsp(rsp),
		.supply_ok(sup), .reset_pin_i(rst_w), .reset_pin_o(rst_o), .reset_pin_oe(rst_oe),
		.subset_reset(sub), .intrusion_input(intr), .termination_sense_input(term),
		.battery_rail_value(bat), .intrusion_armed(armed), .alert(alert),
		.main_rail(main_rail), .dedicated_fan_prog(prog), .early_mon_en(emon),
		.all_mon_en(amon), .quiet_start_gate(qgate), .fan_shared_oe(fsh),
		.dedicated_fan_drive(fan3), .xor_in(xin), .xor_pin_o(xor_o), .xor_pin_oe(xor_oe));

	rpc_board_model #(.HOLD(8)) board (
		.clk_sys(clk_sys), .reset_pin_o(rst_o), .reset_pin_oe(rst_oe), .xor_pin_o(xor_o),
		.xor_pin_oe(xor_oe), .ext_req(ext_req), .reset_wire(rst_w), .xor_wire(xor_w));

	// --------------------
	// Tasks
	// --------------------
	task automatic test_done;
		$display("Checks %0d, errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// Write address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic aw = 0;
		logic w = 0;
		int n = 0;
		req.awaddr <= {2'h0, idx, 2'h0};
		req.wdata <= {24'h0, d};
		req.wstrb <= 4'hf;
		req.awvalid <= 1;
		req.wvalid <= 1;
		while (!(aw && w) && n < 100) begin
			@(posedge clk_sys);
			n++;
			if (!aw && rsp.awready === 1'b1) begin
				aw = 1;
				req.awvalid <= 0;
			end
			if (!w && rsp.wready === 1'b1) begin
				w = 1;
				req.wvalid <= 0;
			end
		end
		while (rsp.bvalid !== 1'b1 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		chk(n < 100, 1);
		chk(rsp.bresp, er);
	endtask

	task automatic rdr(input logic [7:0] idx);
		int n = 0;
		req.araddr <= {2'h0, idx, 2'h0};
		req.arvalid <= 1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (rsp.arready !== 1'b1 && n < 100);
		req.arvalid <= 0;
		while (rsp.rvalid !== 1'b1 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		chk(n < 100, 1);
		rd = rsp.rdata;
		rr = rsp.rresp;
	endtask

	task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
		rdr(idx);
		chk(rd, {24'h0, exp});
		chk(rr, 2'h0);
	endtask

	// --------------------
	// Scenarios
	// --------------------
	task automatic t_por;
		int n = 0;
		chk(rst_oe, 1);
		while (rst_oe === 1'b1 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		chk(n >= 20 && n <= 26, 1);
		chk(emon, 1);
		chk(fsh, 3'h0);
		chk(amon, 0);
	endtask

	task automatic t_def;
		logic [15:0] tbl [6] = '{16'h0020, 16'h0181, 16'h0300, 16'h3500, 16'h7580, 16'h7b00};
		foreach (tbl[i])
			rc(tbl[i][15:8], tbl[i][7:0]);
		rdr(8'h02);
		chk(rr, 2'h2);
		wr(8'h02, 8'h55, 2'h2);
		wr(8'h01, 8'ha1, 2'h0);
		tick(2);
		chk(amon, 1);
	endtask

	task automatic t_term;
		term <= 2'b01;
		tick(5);
		rc(8'hbe, 8'h10);
		rc(8'hc6, 8'h10);
		chk(alert, 1);
		term <= 2'b00;
		wr(8'h35, 8'h30, 2'h0);
		wr(8'hbe, 8'h30, 2'h0);
		wr(8'hc6, 8'h30, 2'h0);
		term <= 2'b10;
		tick(5);
		rc(8'hbe, 8'h20);
		chk(alert, 0);
		term <= 2'b00;
		wr(8'h35, 8'h00, 2'h0);
		tick(2);
		chk(alert, 1);
		wr(8'hbe, 8'h30, 2'h0);
		wr(8'hc6, 8'h30, 2'h0);
		tick(2);
		chk(alert, 0);
	endtask

	task automatic t_intr;
		intr <= 1;
		tick(3);
		intr <= 0;
		tick(4);
		rc(8'hbe, 8'h80);
		chk(alert, 0);
		main_rail <= 1;
		tick(6);
		chk(alert, 1);
		chk(qcnt, 1);
		chk(fan3, 0);
		tick(60);
		chk(fan3, 1);
		wr(8'h03, 8'h20, 2'h0);
		tick(2);
		rc(8'hbe, 8'h00);
		wr(8'h03, 8'h00, 2'h0);
		rc(8'hbe, 8'h00);
		chk(alert, 0);
		bat <= 8'h10;
		tick(1);
		chk(armed, 0);
		intr <= 1;
		tick(3);
		intr <= 0;
		tick(4);
		rc(8'hbe, 8'h00);
		bat <= 8'h90;
		rc(8'h93, 8'h90);
	endtask

	task automatic t_xor;
		chk(xor_w, 1);
		wr(8'h03, 8'h40, 2'h0);
		tick(4);
		chk(xor_w, 0);
		for (int i = 0; i < 8; i++) begin
			xin[i] <= 1'b1;
			tick(5);
			chk(xor_w, ^xin);
		end
	endtask

	task automatic t_swrst;
		int s0;
		wr(8'h00, 8'h80, 2'h0);
		rc(8'h03, 8'h40);
		wr(8'h75, 8'h70, 2'h0);
		wr(8'h7b, 8'h6d, 2'h0);
		s0 = scnt;
		wr(8'h00, 8'h80, 2'h0);
		tick(3);
		chk(scnt - s0, 1);
		rc(8'h03, 8'h00);
		rc(8'h01, 8'h81);
		rc(8'h7b, 8'h00);
		rc(8'h75, 8'h70);
	endtask

	task automatic t_hwrst;
		int s0;
		wr(8'h03, 8'h40, 2'h0);
		wr(8'h75, 8'h60, 2'h0);
		s0 = scnt;
		ext_req <= 1;
		tick(1);
		ext_req <= 0;
		tick(40);
		chk(scnt > s0, 1);
		chk(rst_w, 1);
		rc(8'h03, 8'h00);
		rc(8'h75, 8'h60);
	endtask

	task automatic t_lock;
		int s0;
		wr(8'h01, 8'he1, 2'h0);
		wr(8'h03, 8'h40, 2'h0);
		rc(8'h03, 8'h00);
		s0 = scnt;
		ext_req <= 1;
		tick(1);
		ext_req <= 0;
		tick(40);
		chk(scnt > s0, 1);
		rc(8'h01, 8'he1);
		chk(amon, 1);
	endtask

	task automatic t_brown;
		int n = 0;
		sup <= 0;
		tick(4);
		chk(rst_oe, 1);
		sup <= 1;
		while (rst_oe === 1'b1 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		chk(n >= 20 && n <= 26, 1);
		tick(10);
		chk(rst_w, 1);
	endtask

	initial begin
		tick(20);
		srst <= 0;
		t_por;
		t_def;
		t_term;
		t_intr;
		t_xor;
		t_swrst;
		t_hwrst;
		t_lock;
		t_brown;
		test_done;
	end

	initial begin
		tick(5000);
		num_errors++;
		test_done;
	end
endmodule
